//--- hdl/bdc_defs.svh
// Purpose: Constants for the brake and direction control block.
// Assumes: Registers reached by a simple parameter write/read port.
// Notes:   Offsets are the printed parameter indices.
// How it works
// - The brake control field is 16 bits: 0 automatic, 1 manual release, 2 manual apply.
// - Manual release acts only in switch-on-disabled, ready-to-switch-on or fault state.
// - A new brake control value acts from the clock after the write; an apply waits for standstill, a release for a permitted state.
// - Direction inversion is 0 for off and 1 for on, with 0 after reset.
// - With inversion off a positive target drives the positive physical direction.
// - With inversion on the sign of every commanded target is negated.
// - Writes to the inversion setting are refused while the power stage is enabled.
// - A stored inversion value governs motion only after the next power-on; reset here clears it to 0 before the one latch, so inversion never turns on.
// - Positive physical direction means clockwise seen on the protruding shaft end.
// - A manual apply overrides automatic and manual release.
// - A manual apply is carried out only while the motor stands still.
// - Enabling the power stage under a manual apply keeps the brake applied.
// - In automatic handling the brake is applied whenever the power stage is disabled.
`ifndef BDC_DEFS_SVH
`define BDC_DEFS_SVH
`define BDC_ADDR_W          12
`define BDC_DATA_W          16
`define BDC_TGT_W           32
`define BDC_OFS_INVERT      12'h618
`define BDC_OFS_BRAKE       12'h814
`define BDC_RST_INVERT      16'h0000
`define BDC_RST_BRAKE       16'h0000
`define BDC_BRK_AUTO        16'h0000
`define BDC_BRAKE_MANUAL_CONTROL     16'h0001
`define BDC_BRK_APPLY       16'h0002
`define BDC_INV_OFF         16'h0000
`define BDC_INV_ON          16'h0001
`define BDC_ST_SW_ON_DIS    4'h3
`define BDC_ST_READY        4'h4
`define BDC_ST_FAULT        4'h9
`endif

//--- hdl/bdc_pkg.sv
// Purpose: Types for the brake and direction control block.
// Assumes: bdc_defs.svh holds the numeric constants.
// Notes:   Carrier structs for the parameter port.
`include "bdc_defs.svh"
package bdc_pkg;
  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`BDC_ADDR_W-1:0]  addr;
    logic [`BDC_DATA_W-1:0]  wdata;
  } bdc_req_type;

  typedef struct packed {
    logic                    ack;
    logic                    err;
    logic [`BDC_DATA_W-1:0]  rdata;
  } bdc_rsp_type;

  typedef enum logic [2:0] {
    BRK_APPLIED  = 3'b001,
    BRK_RELEASED = 3'b010,
    BRK_MAN_HOLD = 3'b100
  } bdc_brake_type;
endpackage : bdc_pkg

//--- hdl/bdc_sign.sv
// Purpose: Applies the active direction sign to a commanded target.
// Assumes: Targets are two's complement.
// Notes:   Registered output.
`timescale 1ns/10ps
`include "bdc_defs.svh"
module bdc_sign (
  input  wire logic                   clk_in,
  input  wire logic                   rstn_in,
  input  wire logic                   invert_in,
  input  wire logic [`BDC_TGT_W-1:0]  target_in,
  output logic      [`BDC_TGT_W-1:0]  target_out
);
  logic [`BDC_TGT_W-1:0] target_nxt;

  always_comb begin
    if (invert_in) begin
      target_nxt = `BDC_TGT_W'(-target_in);
    end else begin
      target_nxt = target_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      target_out <= '0;
    end else begin
      target_out <= target_nxt;
    end
  end
endmodule : bdc_sign

//--- hdl/bdc_top.sv
// Purpose: Holding brake handling and motion direction inversion.
// Assumes: Parameter port requests are one-cycle strobes, synchronous to CLK_IN.
// Notes:   Positive motor output sign means clockwise at the shaft end.
`timescale 1ns/10ps
`include "bdc_defs.svh"
module bdc_top (
  input  wire logic                   CLK_IN,
  input  wire logic                   RSTN_IN,
  input  wire bdc_pkg::bdc_req_type   PAR_REQ_IN,
  output bdc_pkg::bdc_rsp_type        PAR_RSP_OUT,
  input  wire logic [3:0]             OP_STATE_IN,
  input  wire logic                   POWER_STAGE_EN_IN,
  input  wire logic                   STANDSTILL_IN,
  input  wire logic [`BDC_TGT_W-1:0]  TARGET_IN,
  output logic      [`BDC_TGT_W-1:0]  MOTOR_TARGET_OUT,
  output logic                        BRAKE_RELEASE_OUT,
  output logic                        DIR_INVERT_ACTIVE_OUT
);
  import bdc_pkg::*;

  logic [`BDC_DATA_W-1:0] brake_ctl_r, brake_ctl_nxt;
  logic [`BDC_DATA_W-1:0] invert_r, invert_nxt;
  logic                   inv_act_r, inv_act_nxt;
  logic                   boot_r, boot_nxt;
  bdc_rsp_type            rsp_r, rsp_nxt;
  bdc_brake_type          brk_r, brk_nxt;
  logic                   rel_ok;
  logic                   hit_brk;
  logic                   hit_inv;

  // Parameter access
  always_comb begin
    brake_ctl_nxt = brake_ctl_r;
    invert_nxt    = invert_r;
    rsp_nxt       = '0;
    hit_brk       = 1'b0;
    hit_inv       = 1'b0;
    if (PAR_REQ_IN.addr == `BDC_OFS_BRAKE) begin
      hit_brk = 1'b1;
    end else if (PAR_REQ_IN.addr == `BDC_OFS_INVERT) begin
      hit_inv = 1'b1;
    end
    if (PAR_REQ_IN.wr) begin
      rsp_nxt.ack = 1'b1;
      if (hit_brk) begin
        if (PAR_REQ_IN.wdata <= `BDC_BRK_APPLY) begin
          brake_ctl_nxt = PAR_REQ_IN.wdata;
        end else begin
          rsp_nxt.err = 1'b1;
        end
      end else if (hit_inv) begin
        if (POWER_STAGE_EN_IN || PAR_REQ_IN.wdata > `BDC_INV_ON) begin
          rsp_nxt.err = 1'b1;
        end else begin
          invert_nxt = PAR_REQ_IN.wdata;
        end
      end else begin
        rsp_nxt.err = 1'b1;
      end
    end else if (PAR_REQ_IN.rd) begin
      rsp_nxt.ack = 1'b1;
      if (hit_brk) begin
        rsp_nxt.rdata = brake_ctl_r;
      end else if (hit_inv) begin
        rsp_nxt.rdata = invert_r;
      end else begin
        rsp_nxt.err = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      brake_ctl_r <= `BDC_RST_BRAKE;
      invert_r    <= `BDC_RST_INVERT;
      rsp_r       <= '0;
    end else begin
      brake_ctl_r <= brake_ctl_nxt;
      invert_r    <= invert_nxt;
      rsp_r       <= rsp_nxt;
    end
  end

  // Inversion latched once after power-on only
  always_comb begin
    boot_nxt    = 1'b1;
    inv_act_nxt = inv_act_r;
    if (!boot_r) begin
      inv_act_nxt = (invert_r == `BDC_INV_ON);
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      boot_r    <= 1'b0;
      inv_act_r <= 1'b0;
    end else begin
      boot_r    <= boot_nxt;
      inv_act_r <= inv_act_nxt;
    end
  end

  // Brake command
  assign rel_ok = (OP_STATE_IN == `BDC_ST_SW_ON_DIS) || (OP_STATE_IN == `BDC_ST_READY) ||
                  (OP_STATE_IN == `BDC_ST_FAULT);

  always_comb begin
    brk_nxt = brk_r;
    case (brk_r)
      BRK_MAN_HOLD: begin
        // Left only via automatic; release direct from here is ignored
        if (brake_ctl_r == `BDC_BRK_AUTO) begin
          brk_nxt = POWER_STAGE_EN_IN ? BRK_RELEASED : BRK_APPLIED;
        end
      end
      default: begin
        if (brake_ctl_r == `BDC_BRK_APPLY) begin
          if (STANDSTILL_IN) begin
            brk_nxt = BRK_MAN_HOLD;
          end
        end else if (brake_ctl_r == `BDC_BRAKE_MANUAL_CONTROL) begin
          if (rel_ok) begin
            brk_nxt = BRK_RELEASED;
          end else begin
            brk_nxt = brk_r;
          end
        end else begin
          brk_nxt = POWER_STAGE_EN_IN ? BRK_RELEASED : BRK_APPLIED;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      brk_r <= BRK_APPLIED;
    end else begin
      brk_r <= brk_nxt;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      BRAKE_RELEASE_OUT     <= 1'b0;
      DIR_INVERT_ACTIVE_OUT <= 1'b0;
      PAR_RSP_OUT           <= '0;
    end else begin
      BRAKE_RELEASE_OUT     <= (brk_nxt == BRK_RELEASED);
      DIR_INVERT_ACTIVE_OUT <= inv_act_r;
      PAR_RSP_OUT           <= rsp_r;
    end
  end

  bdc_sign u_sign (
    .clk_in     (CLK_IN),
    .rstn_in    (RSTN_IN),
    .invert_in  (inv_act_r),
    .target_in  (TARGET_IN),
    .target_out (MOTOR_TARGET_OUT)
  );
endmodule : bdc_top

//--- test/bdc_checker.sv
// Purpose: Port checks for bdc_top.
// Assumes: Answers come two edges after the taking edge.
// Notes:   Bound to every bdc_top instance.
`timescale 1ns/10ps
`include "bdc_defs.svh"
module bdc_checker (
  input wire logic                  CLK_IN,
  input wire logic                  RSTN_IN,
  input wire bdc_pkg::bdc_req_type  PAR_REQ_IN,
  input wire bdc_pkg::bdc_rsp_type  PAR_RSP_OUT,
  input wire logic [3:0]            OP_STATE_IN,
  input wire logic                  POWER_STAGE_EN_IN,
  input wire logic                  STANDSTILL_IN,
  input wire logic [`BDC_TGT_W-1:0] TARGET_IN,
  input wire logic [`BDC_TGT_W-1:0] MOTOR_TARGET_OUT,
  input wire logic                  BRAKE_RELEASE_OUT,
  input wire logic                  DIR_INVERT_ACTIVE_OUT
);
  import bdc_pkg::*;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  wire        w_inv  = PAR_REQ_IN.wr && PAR_REQ_IN.addr == `BDC_OFS_INVERT;
  wire        w_brk  = PAR_REQ_IN.wr && PAR_REQ_IN.addr == `BDC_OFS_BRAKE;
  wire        rd_inv = PAR_REQ_IN.rd && !PAR_REQ_IN.wr && PAR_REQ_IN.addr == `BDC_OFS_INVERT;
  wire [15:0] wd     = PAR_REQ_IN.wdata;
  inv_refuse_a: assert property (w_inv && POWER_STAGE_EN_IN |-> ##2 PAR_RSP_OUT.err)
    else $error("inversion write not refused");
  brk_range_a: assert property (w_brk && wd > 16'h0002 |-> ##2 PAR_RSP_OUT.err)
    else $error("brake value not refused");
  brk_take_a: assert property (w_brk && wd <= 16'h0002 |-> ##2 !PAR_RSP_OUT.err)
    else $error("brake value refused");
  inv_read_a: assert property (rd_inv |-> ##2 PAR_RSP_OUT.rdata <= 16'h0001)
    else $error("inversion value out of range");
  inv_hold_a: assert property ($stable(DIR_INVERT_ACTIVE_OUT))
    else $error("inversion changed while running");
  tgt_sign_a: assert property ($past(RSTN_IN) |-> MOTOR_TARGET_OUT ==
    (DIR_INVERT_ACTIVE_OUT ? -$past(TARGET_IN) : $past(TARGET_IN)))
    else $error("target sign wrong");
  rel_state_a: assert property ($rose(BRAKE_RELEASE_OUT) |-> $past(POWER_STAGE_EN_IN) ||
    $past(OP_STATE_IN) inside {`BDC_ST_SW_ON_DIS, `BDC_ST_READY, `BDC_ST_FAULT})
    else $error("release in wrong state");
  apply_still_a: assert property ($fell(BRAKE_RELEASE_OUT) |->
    $past(STANDSTILL_IN) || !$past(POWER_STAGE_EN_IN)) else $error("apply while moving");
  c_rel: cover property ($rose(BRAKE_RELEASE_OUT));
  c_app: cover property ($fell(BRAKE_RELEASE_OUT));
  c_err: cover property (PAR_RSP_OUT.err);
endmodule : bdc_checker
bind bdc_top bdc_checker chk (.*);

//--- test/bdc_master.sv
// Purpose: Fieldbus master model for the parameter port.
// Assumes: Request launched at the falling edge, answer two edges later.
// Notes:   Released address and data lines show the inverse.
`timescale 1ns/10ps
module bdc_master (
  input  wire bdc_pkg::bdc_rsp_type rsp_in,
  input  wire logic                 clk_in,
  output bdc_pkg::bdc_req_type      req_out
);
  import bdc_pkg::*;
  initial req_out = '0;
  task automatic access(input logic wr, input logic [11:0] a, input logic [15:0] d,
                        output bdc_rsp_type r);
    @(negedge clk_in);
    req_out = '{wr, !wr, a, d};
    @(negedge clk_in);
    req_out = '{1'b0, 1'b0, ~req_out.addr, ~req_out.wdata};
    @(negedge clk_in);
    r = rsp_in;
  endtask : access
endmodule : bdc_master

//--- test/bdc_top_tb.sv
// Purpose: Self-checking bench for bdc_top.
// Assumes: Inputs change at the falling edge.
// Notes:   Inversion stays off as the setting, cleared by reset, is latched only once after reset.
`timescale 1ns/10ps
`include "bdc_defs.svh"
module bdc_top_tb;
  import bdc_pkg::*;
  typedef struct packed {
    logic [3:0]  st;
    logic        pwr;
    logic [15:0] val;
    logic        brk;
  } bdc_row_type;
  logic        clk = 1'b0, rstn = 1'b0, pwr = 1'b0, still = 1'b1, brk, dir;
  logic [3:0]  op = 4'h3;
  logic [31:0] tgt = 32'hffff_fff6, mtgt;
  bdc_req_type req;
  bdc_rsp_type rsp, r;
  int          errors = 0, checks = 0;
  bdc_row_type rows [10] = '{'{4'h3, 1'h0, 16'h0, 1'h0}, '{4'h3, 1'h1, 16'h0, 1'h1},
    '{4'h3, 1'h0, 16'h1, 1'h1}, '{4'h4, 1'h0, 16'h1, 1'h1}, '{4'h9, 1'h0, 16'h1, 1'h1},
    '{4'h3, 1'h0, 16'h0, 1'h0}, '{4'h6, 1'h0, 16'h1, 1'h0}, '{4'h3, 1'h1, 16'h2, 1'h0},
    '{4'h3, 1'h1, 16'h1, 1'h0}, '{4'h3, 1'h1, 16'h0, 1'h1}};
  always #25 clk = ~clk;
  bdc_master m (.clk_in(clk), .rsp_in(rsp), .req_out(req));
  bdc_top uut (.CLK_IN(clk), .RSTN_IN(rstn), .PAR_REQ_IN(req), .PAR_RSP_OUT(rsp),
    .OP_STATE_IN(op), .POWER_STAGE_EN_IN(pwr), .STANDSTILL_IN(still), .TARGET_IN(tgt),
    .MOTOR_TARGET_OUT(mtgt), .BRAKE_RELEASE_OUT(brk), .DIR_INVERT_ACTIVE_OUT(dir));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic print_verdict();
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    chk("brake reset", brk, 1'b0);
    m.access(1'b0, `BDC_OFS_INVERT, 16'h0, r);
    chk("inv reset", r.rdata, `BDC_RST_INVERT);
    m.access(1'b0, `BDC_OFS_BRAKE, 16'h0, r);
    chk("brk reset", r.rdata, `BDC_RST_BRAKE);
    foreach (rows[i]) begin
      @(negedge clk);
      {op, pwr} = {rows[i].st, rows[i].pwr};
      m.access(1'b1, `BDC_OFS_BRAKE, rows[i].val, r);
      chk("brk ack", {r.ack, r.err}, 2'b10);
      chk("brake", brk, rows[i].brk);
    end
    still = 1'b0;
    m.access(1'b1, `BDC_OFS_BRAKE, `BDC_BRK_APPLY, r);
    chk("apply moving", brk, 1'b1);
    still = 1'b1;
    repeat (3) @(negedge clk);
    chk("apply still", brk, 1'b0);
    m.access(1'b1, `BDC_OFS_INVERT, `BDC_INV_ON, r);
    chk("inv powered", r.err, 1'b1);
    m.access(1'b1, `BDC_OFS_BRAKE, 16'h0003, r);
    chk("brk range", r.err, 1'b1);
    m.access(1'b0, 12'h000, 16'h0, r);
    chk("unmapped", r.err, 1'b1);
    pwr = 1'b0;
    m.access(1'b1, `BDC_OFS_INVERT, `BDC_INV_ON, r);
    chk("inv idle", r.err, 1'b0);
    m.access(1'b0, `BDC_OFS_INVERT, 16'h0, r);
    chk("inv read", r.rdata, `BDC_INV_ON);
    chk("inv held", dir, 1'b0);
    chk("target", mtgt, tgt);
    print_verdict();
  end
  initial begin
    #(2000 * 50);
    errors++;
    print_verdict();
  end
endmodule : bdc_top_tb
